// file: design/sfc_defines.svh
// sfc_defines.svh: opcodes, field positions, reset values and timing
// counts shared by the flash device end and the host end.
// assumes a single 25 MHz clock for both ends.
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

// opcodes
`define SFC_OP_READ     8'h52
`define SFC_OP_STAT     8'h83
`define SFC_OP_CLR      8'h89
`define SFC_OP_ID       8'h85
`define SFC_OP_PROG     8'hF2
`define SFC_OP_SERASE   8'hF1
`define SFC_OP_CERASE   8'hF4

// status byte bit positions and power-up value
`define SFC_ST_BUSY     7
`define SFC_ST_ERR_ER   4
`define SFC_ST_ERR_PG   3
`define SFC_ST_READY    0
`define SFC_ST_RESET    8'h01

// byte index of the last location byte, of the last dummy byte and of the last erase location byte
`define SFC_LAST_LOC    4'h4
`define SFC_LAST_DUMMY  4'h8
`define SFC_LAST_ERLOC  4'h2

// modelled array, page and segment sizes
`define SFC_ARRAY_AW    12
`define SFC_PAGE_AW     7
`define SFC_SEG_AW      9

// timing
`define SFC_CLK_NS      40
`define SFC_PROG_MS     5
`define SFC_ERASE_MS    300
`define SFC_PROG_CYC    ((`SFC_PROG_MS * 1000000) / `SFC_CLK_NS)
`define SFC_ERASE_CYC   ((`SFC_ERASE_MS * 1000000) / `SFC_CLK_NS)
`define SFC_CSA_NS      50
`define SFC_CSB_NS      50
`define SFC_CSH_NS      100
`define SFC_SKH_NS      25
`define SFC_CEIL(ns)    (((ns) + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`define SFC_CSA_CYC     `SFC_CEIL(`SFC_CSA_NS)
`define SFC_CSB_CYC     `SFC_CEIL(`SFC_CSB_NS)
`define SFC_CSH_CYC     `SFC_CEIL(`SFC_CSH_NS)
`define SFC_SKH_CYC     `SFC_CEIL(`SFC_SKH_NS)

// host register map
`define SFC_HR_CMD      4'h0
`define SFC_HR_ADDR     4'h4
`define SFC_HR_DATA     4'h8
`define SFC_HR_USEADDR  16

`endif

// file: design/sfc_pkg.sv
// sfc_pkg: state types of the flash device end and the host end.
// assumes nothing beyond the defines header.
package sfc_pkg;

   typedef enum logic [3:0] {
      ST_IDLE, ST_CMD, ST_RADDR, ST_READ, ST_STAT, ST_CLR, ST_IDDUM,
      ST_ID, ST_PADDR, ST_PROG, ST_EADDR, ST_EARM, ST_STBY
   } sfc_dev_st_e;

   typedef enum logic [1:0] {
      EN_IDLE, EN_PROG, EN_ERASE, EN_WAIT
   } sfc_eng_st_e;

   typedef enum logic [2:0] {
      HS_IDLE, HS_LEAD, HS_HIGH, HS_LOW, HS_LAG, HS_GAP
   } sfc_host_st_e;

endpackage

// file: design/sfc_link_if.sv
// sfc_link_if: chip-select framed serial link between host and device.
// assumes both ends run on the same clock; so floats high when undriven.
`timescale 1ns/100ps
interface sfc_link_if;
   logic cs_n;     // chip select, active low
   logic sclk;     // serial clock made by the host
   logic si;       // host to device data
   logic so;       // device to host data
   logic so_oe;    // device drives so
   logic so_line;  // resolved so wire level

   // pull-up model of the undriven output wire
   assign so_line = so_oe ? so : 1'b1;

   modport dev  (input cs_n, sclk, si, output so, so_oe);
   modport host (output cs_n, sclk, si, input so_line);
endinterface

// file: design/sfc_flash_dev.sv
// sfc_flash_dev: command engine of a serial flash on the link.
// assumes the host drives cs_n, sclk and si from the same mclk_i domain.
`timescale 1ns/100ps
`include "sfc_defines.svh"
module sfc_flash_dev #(
   parameter int         PROG_CYC  = `SFC_PROG_CYC,
   parameter int         ERASE_CYC = `SFC_ERASE_CYC,
   parameter logic [7:0] MFR_ID    = 8'h3A,  // arbitrary value
   parameter logic [7:0] DEV_ID    = 8'h5C   // arbitrary value
) (
   input  wire logic mclk_i,
   input  wire logic rst_i,
   input  wire logic erase_fault_i,
   output logic      busy_o,
   sfc_link_if.dev   link
);
   import sfc_pkg::*;

   localparam int AW = `SFC_ARRAY_AW;
   localparam int PW = `SFC_PAGE_AW;

   sfc_dev_st_e        state, next_state;
   logic [2:0]         bitcnt, next_bitcnt;
   logic [3:0]         bytecnt, next_bytecnt;
   logic [7:0]         shin, next_shin;
   logic [7:0]         tx, next_tx;
   logic               so_oe, next_oe;
   logic [20:0]        a, next_a;
   logic               pend, next_pend;
   logic               cs_q, sclk_q;
   logic [(1<<PW)-1:0] pvalid, next_pvalid;
   logic [7:0]         pbuf [0:(1<<PW)-1];
   logic [7:0]         mem  [0:(1<<AW)-1];
   logic               sclk_rise, start_prog, start_erase, clr_flags;
   logic               buf_we;
   logic [7:0]         byte_in, stat_byte;
   logic [AW-1:0]      rd_idx;
   logic [8:0]         seg_inc;

   sfc_eng_st_e        eng, next_eng;
   logic [AW-1:0]      eidx, next_eidx;
   logic [22:0]        etimer, next_etimer;
   logic [AW-1:PW]     base, next_base;
   logic               op_prog, next_op_prog;
   logic               fail, next_fail;
   logic               err_p, next_err_p;
   logic               err_e, next_err_e;
   logic               busy, next_busy;
   logic               mem_we;
   logic [AW-1:0]      mem_wa;
   logic [7:0]         mem_wd;

   // place one location byte into the address by its index
   function automatic logic [20:0] loc_update(input logic [20:0] cur,
                                              input logic [3:0]  idx,
                                              input logic [7:0]  b);
      logic [20:0] r;
      r = cur;
      unique case (idx)
         4'h1:    r[20:17] = b[3:0];
         4'h2:    r[16:9]  = b;
         4'h3:    r[8:7]   = b[1:0];
         4'h4:    r[6:0]   = b[6:0];
         default: r = cur;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // link side: byte assembly and command decoding

   // status byte, reserved bits held at zero
   always_comb begin
      stat_byte                = 8'h00;
      stat_byte[`SFC_ST_BUSY]  = busy;
      stat_byte[`SFC_ST_ERR_ER] = err_e;
      stat_byte[`SFC_ST_ERR_PG] = err_p;
      stat_byte[`SFC_ST_READY] = ~busy;
   end

   assign sclk_rise = link.sclk & ~sclk_q;
   assign byte_in   = {shin[6:0], link.si};
   assign seg_inc   = a[8:0] + 9'h001;
   assign rd_idx    = (state == ST_READ) ?
                      {a[AW-1:9], seg_inc} : a[AW-1:0];

   // next values of the command decoder
   always_comb begin
      next_state   = state;
      next_bitcnt  = bitcnt;
      next_bytecnt = bytecnt;
      next_shin    = shin;
      next_tx      = tx;
      next_oe      = so_oe;
      next_a       = a;
      next_pend    = pend;
      next_pvalid  = pvalid;
      start_prog   = 1'b0;
      start_erase  = 1'b0;
      clr_flags    = 1'b0;
      buf_we       = 1'b0;
      if (link.cs_n) begin
         next_oe    = 1'b0;
         next_state = ST_IDLE;
         if (!cs_q) begin
            start_prog  = (state == ST_PROG) && pend;
            start_erase = (state == ST_EARM);
         end
      end else if (cs_q) begin
         next_state   = ST_CMD;
         next_bitcnt  = 3'h0;
         next_bytecnt = 4'h0;
         next_oe      = 1'b0;
      end else if (sclk_rise) begin
         next_shin   = byte_in;
         next_bitcnt = bitcnt + 3'h1;
         next_tx     = {tx[6:0], 1'b0};
         if (bitcnt == 3'h7) begin
            if (bytecnt != 4'hF) begin
               next_bytecnt = bytecnt + 4'h1;
            end
            unique case (state)
               ST_CMD: begin
                  unique case (byte_in)
                     `SFC_OP_READ: begin
                        next_state = busy ? ST_STBY : ST_RADDR;
                     end
                     `SFC_OP_STAT: begin
                        next_state = ST_STAT;
                        next_tx    = stat_byte;
                        next_oe    = 1'b1;
                     end
                     `SFC_OP_CLR: begin
                        next_state = ST_CLR;
                        clr_flags  = 1'b1;
                     end
                     `SFC_OP_ID: begin
                        next_state = ST_IDDUM;
                        next_a[0]  = 1'b0;
                     end
                     `SFC_OP_PROG: begin
                        next_state  = busy ? ST_STBY : ST_PADDR;
                        next_pend   = 1'b0;
                        next_pvalid = '0;
                     end
                     `SFC_OP_SERASE, `SFC_OP_CERASE: begin
                        next_state = busy ? ST_STBY : ST_EADDR;
                     end
                     default: next_state = ST_STBY;
                  endcase
               end
               ST_RADDR: begin
                  next_a = loc_update(a, bytecnt, byte_in);
                  if (bytecnt == `SFC_LAST_DUMMY) begin
                     next_state = ST_READ;
                     next_tx    = mem[rd_idx];
                     next_oe    = 1'b1;
                  end
               end
               ST_READ: begin
                  next_a[8:0] = seg_inc;
                  next_tx     = mem[rd_idx];
               end
               ST_STAT: next_tx = stat_byte;
               ST_IDDUM: begin
                  next_state = ST_ID;
                  next_tx    = MFR_ID;
                  next_oe    = 1'b1;
                  next_a[0]  = 1'b1;
               end
               ST_ID: begin
                  next_tx   = a[0] ? DEV_ID : MFR_ID;
                  next_a[0] = ~a[0];
               end
               ST_PADDR: begin
                  next_a = loc_update(a, bytecnt, byte_in);
                  if (bytecnt == `SFC_LAST_LOC) begin
                     next_state = ST_PROG;
                  end
               end
               ST_PROG: begin
                  buf_we              = 1'b1;
                  next_pend           = 1'b1;
                  next_pvalid[a[6:0]] = 1'b1;
                  next_a[6:0]         = a[6:0] + 7'h01;
               end
               ST_EADDR: begin
                  next_a = loc_update(a, bytecnt, byte_in);
                  if (bytecnt == `SFC_LAST_ERLOC) begin
                     next_state = ST_EARM;
                  end
               end
               ST_IDLE, ST_CLR, ST_EARM, ST_STBY: next_state = state;
            endcase
         end
      end
   end

   // register the command decoder
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state   <= ST_IDLE;
         bitcnt  <= 3'h0;
         bytecnt <= 4'h0;
         shin    <= 8'h00;
         tx      <= 8'h00;
         so_oe   <= 1'b0;
         a       <= 21'h000000;
         pend    <= 1'b0;
         pvalid  <= '0;
         cs_q    <= 1'b1;
         sclk_q  <= 1'b0;
      end else begin
         state   <= next_state;
         bitcnt  <= next_bitcnt;
         bytecnt <= next_bytecnt;
         shin    <= next_shin;
         tx      <= next_tx;
         so_oe   <= next_oe;
         a       <= next_a;
         pend    <= next_pend;
         pvalid  <= next_pvalid;
         cs_q    <= link.cs_n;
         sclk_q  <= link.sclk;
      end
   end

   // page buffer
   always_ff @(posedge mclk_i) begin
      if (buf_we) begin
         pbuf[a[6:0]] <= byte_in;
      end
   end

   assign link.so    = tx[7];
   assign link.so_oe = so_oe;
   assign busy_o     = busy;

   ////////////////////////////////////////////////////////////////////////
   // program and erase engine

   // next values of the engine
   always_comb begin
      next_eng     = eng;
      next_eidx    = eidx;
      next_etimer  = etimer;
      next_base    = base;
      next_op_prog = op_prog;
      next_fail    = fail;
      next_err_p   = err_p & ~clr_flags;
      next_err_e   = err_e & ~clr_flags;
      mem_we       = 1'b0;
      mem_wa       = eidx;
      mem_wd       = 8'hFF;
      unique case (eng)
         EN_IDLE: begin
            next_eidx = '0;
            next_fail = 1'b0;
            if (start_prog) begin
               next_eng     = EN_PROG;
               next_base    = a[AW-1:PW];
               next_op_prog = 1'b1;
            end else if (start_erase) begin
               next_eng     = EN_ERASE;
               next_op_prog = 1'b0;
            end
         end
         EN_PROG: begin
            mem_wa    = {base, eidx[PW-1:0]};
            mem_wd    = mem[mem_wa] & pbuf[eidx[PW-1:0]];
            mem_we    = pvalid[eidx[PW-1:0]];
            next_eidx = eidx + 1'b1;
            if (mem_we && (mem_wd != pbuf[eidx[PW-1:0]])) begin
               next_fail = 1'b1;
            end
            if (&eidx[PW-1:0]) begin
               next_eng    = EN_WAIT;
               next_etimer = 23'(PROG_CYC - 1);
            end
         end
         EN_ERASE: begin
            mem_we    = 1'b1;
            next_eidx = eidx + 1'b1;
            if (&eidx) begin
               next_eng    = EN_WAIT;
               next_etimer = 23'(ERASE_CYC - 1);
            end
         end
         EN_WAIT: begin
            next_etimer = etimer - 23'h000001;
            if (etimer == 23'h000000) begin
               next_eng = EN_IDLE;
               if (op_prog) begin
                  next_err_p = next_err_p | fail;
               end else begin
                  next_err_e = next_err_e | erase_fault_i;
               end
            end
         end
      endcase
      next_busy = (next_eng != EN_IDLE);
   end

   // register the engine
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         eng     <= EN_IDLE;
         eidx    <= '0;
         etimer  <= 23'h000000;
         base    <= '0;
         op_prog <= 1'b0;
         fail    <= 1'b0;
         err_p   <= 1'b0;
         err_e   <= 1'b0;
         busy    <= 1'b0;
      end else begin
         eng     <= next_eng;
         eidx    <= next_eidx;
         etimer  <= next_etimer;
         base    <= next_base;
         op_prog <= next_op_prog;
         fail    <= next_fail;
         err_p   <= next_err_p;
         err_e   <= next_err_e;
         busy    <= next_busy;
      end
   end

   // flash array, aliased to its low address bits
   always_ff @(posedge mclk_i) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end
endmodule // sfc_flash_dev

// file: design/sfc_host_ctrl.sv
// sfc_host_ctrl: host end that frames commands on the serial link.
// assumes the device end shares mclk_i; software uses the plain port.
`timescale 1ns/100ps
`include "sfc_defines.svh"
module sfc_host_ctrl (
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   sfc_link_if.host         link
);
   import sfc_pkg::*;

   sfc_host_st_e hst, next_hst;
   logic [1:0]   cnt, next_cnt;
   logic [2:0]   bitc, next_bitc;
   logic [7:0]   bidx, next_bidx;
   logic [7:0]   nbytes, next_nbytes;
   logic [7:0]   op, next_op;
   logic         use_addr, next_use_addr;
   logic [20:0]  loc, next_loc;
   logic [7:0]   fill, next_fill;
   logic [7:0]   txsh, next_txsh;
   logic [7:0]   rxsh, next_rxsh;
   logic [7:0]   rxbyte, next_rxbyte;
   logic         cs_n, next_cs_n;
   logic         sclk, next_sclk;
   logic         si, next_si;
   logic [31:0]  rdata, next_rdata;
   logic [7:0]   nb;

   // byte sent at a given position of the frame
   function automatic logic [7:0] frame_byte(input logic [7:0] idx);
      unique case (idx)
         8'h00:   return op;
         8'h01:   return use_addr ? {4'h0, loc[20:17]} : fill;
         8'h02:   return use_addr ? loc[16:9] : fill;
         8'h03:   return use_addr ? {6'h00, loc[8:7]} : fill;
         8'h04:   return use_addr ? {1'b0, loc[6:0]} : fill;
         default: return fill;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register port and frame sequencer

   assign nb = bidx + 8'h01;

   // next values
   always_comb begin
      next_hst      = hst;
      next_cnt      = cnt;
      next_bitc     = bitc;
      next_bidx     = bidx;
      next_nbytes   = nbytes;
      next_op       = op;
      next_use_addr = use_addr;
      next_loc      = loc;
      next_fill     = fill;
      next_txsh     = txsh;
      next_rxsh     = rxsh;
      next_rxbyte   = rxbyte;
      next_cs_n     = cs_n;
      next_sclk     = sclk;
      next_si       = si;
      next_rdata    = 32'h00000000;
      if (rd_i) begin
         unique case (addr_i)
            `SFC_HR_CMD:  next_rdata = {31'h00000000, hst != HS_IDLE};
            `SFC_HR_ADDR: next_rdata = {11'h000, loc};
            `SFC_HR_DATA: next_rdata = {24'h000000, rxbyte};
            default:      next_rdata = 32'h00000000;
         endcase
      end
      if (wr_i && addr_i == `SFC_HR_ADDR) begin
         next_loc = wdata_i[20:0];
      end
      if (wr_i && addr_i == `SFC_HR_DATA) begin
         next_fill = wdata_i[7:0];
      end
      unique case (hst)
         HS_IDLE: begin
            if (wr_i && addr_i == `SFC_HR_CMD && wdata_i[15:8] != 8'h00) begin
               next_op       = wdata_i[7:0];
               next_nbytes   = wdata_i[15:8];
               next_use_addr = wdata_i[`SFC_HR_USEADDR];
               next_txsh     = wdata_i[7:0];
               next_si       = wdata_i[7];
               next_cs_n     = 1'b0;
               next_bidx     = 8'h00;
               next_bitc     = 3'h0;
               next_cnt      = 2'(`SFC_CSA_CYC - 1);
               next_hst      = HS_LEAD;
            end
         end
         HS_LEAD, HS_LOW: begin
            next_cnt = cnt - 2'h1;
            if (cnt == 2'h0) begin
               next_sclk = 1'b1;
               next_rxsh = {rxsh[6:0], link.so_line};
               next_cnt  = 2'(`SFC_SKH_CYC - 1);
               next_hst  = HS_HIGH;
            end
         end
         HS_HIGH: begin
            next_cnt = cnt - 2'h1;
            if (cnt == 2'h0) begin
               next_sclk = 1'b0;
               next_bitc = bitc + 3'h1;
               next_cnt  = 2'(`SFC_SKH_CYC - 1);
               next_hst  = HS_LOW;
               next_txsh = {txsh[6:0], 1'b0};
               next_si   = txsh[6];
               if (bitc == 3'h7) begin
                  next_bidx   = nb;
                  next_rxbyte = rxsh;
                  next_txsh   = frame_byte(nb);
                  next_si     = next_txsh[7];
                  if (nb == nbytes) begin
                     next_cnt = 2'(`SFC_CSB_CYC - 1);
                     next_hst = HS_LAG;
                  end
               end
            end
         end
         HS_LAG: begin
            next_cnt = cnt - 2'h1;
            if (cnt == 2'h0) begin
               next_cs_n = 1'b1;
               next_cnt  = 2'(`SFC_CSH_CYC - 1);
               next_hst  = HS_GAP;
            end
         end
         HS_GAP: begin
            next_cnt = cnt - 2'h1;
            if (cnt == 2'h0) begin
               next_hst = HS_IDLE;
            end
         end
      endcase
   end

   // register the sequencer
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         hst      <= HS_IDLE;
         cnt      <= 2'h0;
         bitc     <= 3'h0;
         bidx     <= 8'h00;
         nbytes   <= 8'h00;
         op       <= 8'h00;
         use_addr <= 1'b0;
         loc      <= 21'h000000;
         fill     <= 8'h00;
         txsh     <= 8'h00;
         rxsh     <= 8'h00;
         rxbyte   <= 8'h00;
         cs_n     <= 1'b1;
         sclk     <= 1'b0;
         si       <= 1'b0;
         rdata    <= 32'h00000000;
      end else begin
         hst      <= next_hst;
         cnt      <= next_cnt;
         bitc     <= next_bitc;
         bidx     <= next_bidx;
         nbytes   <= next_nbytes;
         op       <= next_op;
         use_addr <= next_use_addr;
         loc      <= next_loc;
         fill     <= next_fill;
         txsh     <= next_txsh;
         rxsh     <= next_rxsh;
         rxbyte   <= next_rxbyte;
         cs_n     <= next_cs_n;
         sclk     <= next_sclk;
         si       <= next_si;
         rdata    <= next_rdata;
      end
   end

   assign link.cs_n = cs_n;
   assign link.sclk = sclk;
   assign link.si   = si;
   assign rdata_o   = rdata;
endmodule // sfc_host_ctrl

// file: tb/sfc_link_properties.sv
// sfc_link_properties: framing and output-enable checks on the link.
// assumes one clock and a synchronous reset shared by both ends.
`timescale 1ns/100ps
module sfc_link_properties (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   input wire logic so_oe
);
   logic [9:0] n;
   logic [7:0] op;
   logic       sq;
   wire        ok = op inside {8'h52, 8'h83, 8'h89, 8'h85, 8'hF1, 8'hF2,
                               8'hF4};
   // counts sclk rises in a frame and keeps the opcode byte
   always_ff @(posedge mclk_i) begin
      sq <= sclk;
      if (rst_i || cs_n)
         n <= 10'h000;
      else if (sclk && !sq)
         n <= n + 10'h001;
      if (sclk && !sq && n < 10'h008)
         op <= {op[6:0], si};
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence lead_s;
      !sclk ##1 !sclk;
   endsequence
   a_idle_float: assert property (cs_n [*2] |-> !so_oe)
      else $error("so driven while deselected");
   a_bad_op: assert property (n >= 10'h008 && !ok |-> !so_oe)
      else $error("so driven after unknown opcode");
   a_clear_float: assert property (
      n >= 10'h008 && op == 8'h89 |-> !so_oe)
      else $error("so driven during clear");
   a_cmd_quiet: assert property (!cs_n && n < 10'h008 |-> !so_oe)
      else $error("so driven during opcode");
   a_read_wait: assert property (
      op == 8'h52 && n >= 10'h008 && n < 10'h048 |-> !so_oe)
      else $error("read data before tenth byte");
   a_read_data: assert property (
      op == 8'h52 && n >= 10'h049 && !cs_n |-> so_oe)
      else $error("read data missing from tenth byte");
   a_id_out: assert property (
      op == 8'h85 && n >= 10'h011 && !cs_n |-> so_oe)
      else $error("id bytes missing after dummy");
   a_clk_pulse: assert property ($rose(sclk) |=> !sclk)
      else $error("sclk high too long");
   a_lead_time: assert property ($fell(cs_n) |-> lead_s)
      else $error("sclk rose too soon after select");
   a_whole_bytes: assert property ($rose(cs_n) |-> n[2:0] == 3'h0)
      else $error("frame ended inside a byte");
endmodule // sfc_link_properties

// file: tb/serial_flash_command_engine_test.sv
// serial_flash_command_engine_test: host port tests across the link.
// assumes host and device ends share one 25 MHz clock.
`timescale 1ns/100ps
`include "sfc_defines.svh"
module serial_flash_command_engine_test;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        fault = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic [31:0] d;
   logic        busy;
   logic [20:0] ra [4] = '{21'h27F, 21'h201, 21'h3FF, 21'h200};
   logic [7:0]  rn [4] = '{8'h0A, 8'h0A, 8'h0B, 8'h0A};
   logic [7:0]  re [4] = '{8'h3C, 8'hFF, 8'h3C, 8'h3C};
   int          errors = 0;
   int          n_checks = 0;
   int          cyc = 0;
   sfc_link_if link ();
   sfc_flash_dev #(.PROG_CYC(20), .ERASE_CYC(30)) sfc_flash_dev_inst (
      .mclk_i(mclk_i), .rst_i(rst_i), .erase_fault_i(fault),
      .busy_o(busy), .link(link));
   sfc_host_ctrl sfc_host_ctrl_inst (.mclk_i(mclk_i), .rst_i(rst_i),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .link(link));
   sfc_link_properties sfc_link_properties_inst (.mclk_i(mclk_i),
      .rst_i(rst_i), .cs_n(link.cs_n), .sclk(link.sclk), .si(link.si),
      .so_oe(link.so_oe));
   // clock and a cycle ceiling against a hung handshake
   initial begin
      forever #20 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors++;
         results();
      end
   end
   task results();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e)
         $display("ERROR %s expected %h seen %h", s, e, g);
      if (g !== e)
         errors++;
   endtask
   // one register access; read data land in d
   task acc(input logic w, input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      addr <= a;
      wdata <= v;
      wr <= w;
      rd <= !w;
      @(posedge mclk_i);
      wr <= 1'b0;
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // one framed command; d ends holding the last byte seen on so
   task run(input logic [7:0] op, input logic [7:0] n,
            input logic [20:0] a, input logic [7:0] f);
      acc(1'b1, `SFC_HR_ADDR, {11'h0, a});
      acc(1'b1, `SFC_HR_DATA, {24'h0, f});
      // location bytes come from the address register only when it is set
      acc(1'b1, `SFC_HR_CMD, {15'h0, |a, n, op});
      for (int i = 0; i < 300; i++) begin
         acc(1'b0, `SFC_HR_CMD, 32'h0);
         if (d[0] === 1'b0)
            break;
      end
      chk("host idle", 8'h00, {7'h0, d[0]});
      acc(1'b0, `SFC_HR_DATA, 32'h0);
   endtask
   task stat(input logic [7:0] e);
      run(8'h83, 8'h02, 21'h0, 8'h00);
      chk("status", e, d[7:0]);
   endtask
   task settle();
      for (int i = 0; i < 5000 && busy !== 1'b0; i++)
         @(posedge mclk_i);
      chk("busy end", 8'h00, {7'h0, busy});
   endtask
   // tests run in order on one device
   initial begin
      repeat (16) @(posedge mclk_i);
      rst_i <= 1'b0;
      stat(8'h01);
      run(8'h33, 8'h03, 21'h0, 8'h00);
      chk("unknown op so", 8'hFF, d[7:0]);
      for (int i = 3; i < 6; i++) begin
         run(8'h85, 8'(i), 21'h0, 8'h00);
         chk("id byte", i[0] ? 8'h3A : 8'h5C, d[7:0]);
      end
      $display("test id done");
      @(posedge mclk_i);
      fault <= 1'b1;
      run(8'hF1, 8'h03, 21'h0, 8'h00);
      chk("busy run", 8'h01, {7'h0, busy});
      stat(8'h80);
      settle();
      fault <= 1'b0;
      stat(8'h11);
      run(8'h89, 8'h02, 21'h0, 8'h00);
      chk("clear so", 8'hFF, d[7:0]);
      run(8'hF4, 8'h03, 21'h0, 8'h00);
      settle();
      stat(8'h01);
      $display("test erase done");
      run(8'hF2, 8'h07, 21'h27F, 8'h3C);
      stat(8'h80);
      settle();
      foreach (ra[i]) begin
         run(8'h52, rn[i], ra[i], 8'h00);
         chk("array byte", re[i], d[7:0]);
      end
      run(8'hF2, 8'h06, 21'h27F, 8'hFF);
      settle();
      stat(8'h09);
      $display("test program done");
      results();
   end
endmodule // serial_flash_command_engine_test
